// ===== dv/clf_host_model.sv
// clf_host_model: host end of the card link, one data block per frame.
// assumes the card samples data at link clock rise, msb first.
`timescale 1ns/1ps

module clf_host_model
(
  // link pins
  output logic lnk_clk_o,
  output logic lnk_frame_o,
  output logic lnk_dat_o
);
  // link clock stands still outside frames
  initial
  begin
    lnk_clk_o   = 1'b0;
    lnk_frame_o = 1'b0;
    lnk_dat_o   = 1'b1;
  end
  // nbyte bytes from the top of blk, mode byte first
  task automatic send(input int nbyte, input logic [271:0] blk);
    #3; // keeps link edges off the system clock edges
    lnk_frame_o = 1'b1;
    for (int i = 0; i < nbyte * 8; i++)
    begin
      lnk_dat_o = blk[271 - i];
      #24 lnk_clk_o = 1'b1;
      #24 lnk_clk_o = 1'b0;
    end
    #24 lnk_frame_o = 1'b0;
    lnk_dat_o = ~lnk_dat_o; // a released line must not hold its last level
    #48;
  endtask
endmodule

// ===== dv/clf_lock_properties.sv
// clf_lock_properties: bus and status-word checks on the lock engine ports.
// assumes it is bound to clf_lock_top and that clf_params.svh is visible.
`timescale 1ns/1ps
`include "clf_params.svh"

module clf_lock_properties
  import clf_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // link and status
  input wire logic        lnk_clk_i,
  input wire logic        lnk_frame_i,
  input wire logic        lnk_dat_i,
  input wire logic [31:0] card_status_o
);
  logic       frame_q;
  logic [3:0] since_frame;
  logic [3:0] since_erw;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles since a frame ended or erasing was reported done; saturating
  always_ff @(posedge clk_i)
  begin
    frame_q <= lnk_frame_i;
    if (rst_i)
      since_frame <= 4'hf;
    else if (frame_q && !lnk_frame_i)
      since_frame <= 4'h0;
    else if (since_frame != 4'hf)
      since_frame <= since_frame + 4'h1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      since_erw <= 4'hf;
    else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == `CLF_REG_ERASE && wb_dat_i[0])
      since_erw <= 4'h0;
    else if (since_erw != 4'hf)
      since_erw <= since_erw + 4'h1;
  end
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing one cycle after request");
  property p_ack_cause;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i > 8'h0c
      |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_status_bits;
    {card_status_o[31:26], card_status_o[23:0]} == 30'h0;
  endproperty
  a_status_bits: assert property (p_status_bits)
    else $error("status word has stray bits");
  property p_quiet;
    since_frame > 4'ha && since_erw > 4'h6 |-> $stable(card_status_o);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("status changed without a cause");
  property p_fail_cause;
    $rose(card_status_o[`CLF_ST_FAILED]) |-> since_frame <= 4'ha;
  endproperty
  a_fail_cause: assert property (p_fail_cause)
    else $error("failed flag rose without a command");
  property p_lock_fall;
    $fell(card_status_o[`CLF_ST_LOCKED])
      |-> since_frame <= 4'ha || since_erw <= 4'h6;
  endproperty
  a_lock_fall: assert property (p_lock_fall)
    else $error("card unlocked without command or erase end");
endmodule

bind clf_lock_top clf_lock_properties i_props
(
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .lnk_clk_i, .lnk_frame_i, .lnk_dat_i,
  .card_status_o
);

// ===== dv/clf_lock_top_tb_top.sv
// clf_lock_top_tb_top: drives lock commands over the link and registers
// over wishbone. assumes the host model and bound checker are compiled.
`timescale 1ns/1ps
`include "clf_params.svh"

module clf_lock_top_tb_top
  import clf_pkg::*;
;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        lnk_clk;
  logic        lnk_frame;
  logic        lnk_dat;
  logic [31:0] card_status_o;
  int          bad_count = 0;
  int          n_tests   = 0;
  logic [7:0]  bad_m [5] = '{8'h03, 8'h06, 8'h07, 8'h09, 8'h1c};
  clf_lock_top i_dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .lnk_clk_i(lnk_clk), .lnk_frame_i(lnk_frame), .lnk_dat_i(lnk_dat),
    .card_status_o(card_status_o)
  );
  clf_host_model i_host
  (
    .lnk_clk_o(lnk_clk), .lnk_frame_o(lnk_frame), .lnk_dat_o(lnk_dat)
  );
  always #2 clk_i = ~clk_i;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e,
                     input logic [31:0] got);
    n_tests++;
    if (got !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask
  // locked and failed flags of the response word
  task automatic st(input logic [1:0] e);
    cmp("status", {6'h00, e, 24'h0}, card_status_o);
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    // only the watchdog ends a wait for ack
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    cmp($sformatf("reg %h", a), e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  // nb secret bytes; a negative nb sends the one-byte erase block
  task automatic cmd(input int nb, input logic [7:0] m,
                     input logic [63:0] s, input logic [1:0] e);
    i_host.send(nb < 0 ? 1 : nb + 2,
                {m, nb[7:0], s << (64 - 8 * nb), 192'h0});
    @(posedge clk_i);
    st(e);
  endtask
  // software reports the user area erased
  task automatic erase_end();
    wr(`CLF_REG_ERASE, 32'h1);
    repeat (6) @(posedge clk_i);
    st(2'b00);
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  // watchdog: the sequence needs about 35 us
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    st(2'b00);
    rd(`CLF_REG_WPROT, 32'h0);
    rd(`CLF_REG_LENS, 32'h0);
    rd(8'h10, 32'h0);
    fin("reset");
    foreach (bad_m[k]) cmd(0, bad_m[k], 64'h0, 2'b01);
    cmd(-1, 8'h08, 64'h0, 2'b01);
    cmd(2, 8'h05, "PW", 2'b10);
    rd(`CLF_REG_LENS, 32'h2);
    cmd(-1, 8'h0c, 64'h0, 2'b11);
    wr(`CLF_REG_WPROT, 32'h1);
    cmd(-1, 8'h08, 64'h0, 2'b11);
    rd(`CLF_REG_ERASE, 32'h0);
    fin("refused erase");
    wr(`CLF_REG_WPROT, 32'h2);
    cmd(-1, 8'h08, 64'h0, 2'b10);
    rd(`CLF_REG_ERASE, 32'h1);
    rd(`CLF_REG_WPROT, 32'h2);
    erase_end();
    rd(`CLF_REG_WPROT, 32'h0);
    rd(`CLF_REG_LENS, 32'h0);
    fin("plain erase");
    cmd(0, 8'h1f, 64'h0, 2'b00);
    cmd(0, 8'h03, 64'h0, 2'b01);
    cmd(2, 8'h11, "K1", 2'b01);
    cmd(4, 8'h11, "K1K2", 2'b01);
    rd(`CLF_REG_LENS, 32'h200);
    cmd(0, 8'h1f, 64'h0, 2'b01);
    cmd(2, 8'h05, "PW", 2'b10);
    cmd(-1, 8'h08, 64'h0, 2'b11);
    rd(`CLF_REG_LENS, 32'h202);
    fin("key set");
    cmd(2, 8'h18, "K1", 2'b11);
    cmd(0, 8'h18, 64'h0, 2'b11);
    cmd(2, 8'h1c, "K2", 2'b11);
    cmd(2, 8'h18, "K2", 2'b10);
    erase_end();
    rd(`CLF_REG_LENS, 32'h200);
    cmd(2, 8'h18, "K2", 2'b01);
    fin("key erase");
    cmd(2, 8'h12, "K2", 2'b00);
    rd(`CLF_REG_LENS, 32'h0);
    cmd(2, 8'h12, "K2", 2'b01);
    fin("clear key");
    // second reset: key and session are lost, then a key on a locked card
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(`CLF_REG_LENS, 32'h0);
    cmd(2, 8'h05, "PW", 2'b10);
    cmd(2, 8'h11, "K3", 2'b10);
    cmd(2, 8'h01, "PW", 2'b11);
    cmd(0, 8'h1f, 64'h0, 2'b10);
    rd(`CLF_REG_STATUS, 32'h1f1d);
    cmd(0, 8'h1f, 64'h0, 2'b11);
    cmd(2, 8'h00, "PW", 2'b00);
    fin("ownership unlock");
    report_and_stop();
  end
endmodule

// ===== rtl/clf_lock_top.sv
// clf_lock_top: card side lock/unlock command engine with ownership
// protection, override key and force erase, plus a wishbone slave.
// assumes a serial link (clock, frame, data msb first) from the host,
// sampled on clk_i, and software that reports when erasing is finished.
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "clf_params.svh"

// Operation
// - status bit 25 locked, bit 24 failed
// - key stored blocks all until ownership unlock
// - replace takes old+new, or only new
// - protected erase needs locked card with password
// - clear-key erases key, needs stored key
// - set-key stores key, lock and failure kept
// - all flags, no key: enable extended set
// - first ownership unlock enables, unlocks if passwordless
// - repeated or unlocked ownership unlock fails
// - undefined flag combinations fail, no change
// - extra flags in plain erase fail
// - plain erase clears content and password, unlocks
// - plain erase on unlocked card fails
// - plain erase with key stored fails
// - extra flags in protected erase fail
// - protected erase needs exact key, locked card
// - protected erase keeps key, clears password
// - stay locked, protections kept until erase ends
// - permanent write protect refuses force erase
module clf_lock_top
  import clf_pkg::*;
#(
  parameter int SECRET_MAX = `CLF_SECRET_MAX
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // host link pins
  input  wire logic        lnk_clk_i,
  input  wire logic        lnk_frame_i,
  input  wire logic        lnk_dat_i,
  // response status word
  output logic      [31:0] card_status_o
);

  localparam int BLK_MAX = 2 * SECRET_MAX;

  // synchronised pins and edges
  logic [2:0]         pins_s;
  logic               s_clk;
  logic               s_frm;
  logic               s_dat;
  logic               clk_prev;
  logic               frm_prev;
  logic               lnk_rise;
  logic               cmd_go;
  // receive state
  logic [2:0]         bit_cnt;
  logic [7:0]         byte_cnt;
  logic [7:0]         shreg;
  logic [7:0]         next_byte;
  clf_cmd_t           cmd;
  logic [BLK_MAX*8-1:0] blk;
  // card state
  clf_state_t         state;
  clf_card_t          card;
  logic               own_seen;
  logic               ext_en;
  logic [2:0]         wprot;
  logic [4:0]         last_mode;
  // secret stores
  logic [7:0]         password_length;
  logic               pwd_stored;
  logic               pwd_exact;
  logic               pwd_prefix;
  logic               pwd_new_ok;
  logic [7:0]         key_len;
  logic               key_stored;
  logic               key_exact;
  logic               key_prefix;
  logic               key_new_ok;
  // decoded actions
  logic               data_ok;
  logic               act_fail;
  logic               act_keep;
  logic               act_unlock;
  logic               act_lock;
  logic               act_pwd_load;
  logic               act_pwd_clr;
  logic               act_key_load;
  logic               act_key_clr;
  logic               act_own;
  logic               act_ext;
  logic               act_erase;
  logic               erase_fin;
  logic               wb_req;
  logic               wb_wr;

  // all three pins come from the host's domain
  clf_sync #(.WIDTH(3)) u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({lnk_clk_i, lnk_frame_i, lnk_dat_i}),
    .q_o   (pins_s)
  );

  assign s_clk     = pins_s[2];
  assign s_frm     = pins_s[1];
  assign s_dat     = pins_s[0];
  assign lnk_rise  = s_clk && !clk_prev;
  assign cmd_go    = frm_prev && !s_frm && (byte_cnt != 8'h00);
  assign next_byte = {shreg[6:0], s_dat};

  // edge history of the link clock and frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_prev <= 1'b0;
      frm_prev <= 1'b0;
    end
    else
    begin
      clk_prev <= s_clk;
      frm_prev <= s_frm;
    end
  end

  // shift the block in: mode byte, size byte, then secret bytes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 8'h00;
      shreg    <= 8'h00;
      cmd      <= '0;
      blk      <= '0;
    end
    else if (!s_frm)
    begin
      // counters drop only after the end-of-frame cycle has used them
      bit_cnt  <= 3'h0;
      byte_cnt <= 8'h00;
    end
    else if (lnk_rise)
    begin
      shreg   <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7)
      begin
        if (byte_cnt == 8'h00)
        begin
          cmd.mode <= next_byte[4:0];
          cmd.size <= 8'h00;
        end
        else if (byte_cnt == 8'h01)
          cmd.size <= next_byte;
        else if (int'(byte_cnt) - 2 < BLK_MAX)
          blk[(int'(byte_cnt) - 2)*8 +: 8] <= next_byte;
        if (byte_cnt != 8'hff)
          byte_cnt <= byte_cnt + 8'h01;
      end
    end
  end

  // password store
  clf_secret #(.SMAX(SECRET_MAX), .BMAX(BLK_MAX)) u_pwd
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .blk_i    (blk),
    .size_i   (cmd.size),
    .load_i   (act_pwd_load),
    .clear_i  (act_pwd_clr || erase_fin),
    .len_o    (password_length),
    .stored_o (pwd_stored),
    .exact_o  (pwd_exact),
    .prefix_o (pwd_prefix),
    .new_ok_o (pwd_new_ok)
  );

  // override key store
  clf_secret #(.SMAX(SECRET_MAX), .BMAX(BLK_MAX)) u_key
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .blk_i    (blk),
    .size_i   (cmd.size),
    .load_i   (act_key_load),
    .clear_i  (act_key_clr),
    .len_o    (key_len),
    .stored_o (key_stored),
    .exact_o  (key_exact),
    .prefix_o (key_prefix),
    .new_ok_o (key_new_ok)
  );

  // a short block means the secret was not fully provided
  assign data_ok = ({1'b0, byte_cnt} >= ({1'b0, cmd.size} + 9'h002));

  // decode one command into actions; anything unmatched fails
  always_comb
  begin
    act_fail     = 1'b0;
    act_keep     = 1'b0;
    act_unlock   = 1'b0;
    act_lock     = 1'b0;
    act_pwd_load = 1'b0;
    act_pwd_clr  = 1'b0;
    act_key_load = 1'b0;
    act_key_clr  = 1'b0;
    act_own      = 1'b0;
    act_ext      = 1'b0;
    act_erase    = 1'b0;
    if (!cmd_go)
      act_fail = 1'b0;
    else if (state != ST_IDLE)
      act_fail = 1'b1;
    else if (key_stored && !own_seen && cmd.mode != `CLF_M_OWNUNLOCK)
      act_fail = 1'b1;
    else
    begin
      case (cmd.mode)
        `CLF_M_OWNUNLOCK:
        begin
          if (!key_stored)
            act_ext = 1'b1;
          else if (!own_seen && card.locked)
          begin
            act_own    = 1'b1;
            act_unlock = !pwd_stored;
          end
          else
            act_fail = 1'b1;
        end
        `CLF_M_SETKEY:
        begin
          if (data_ok && key_new_ok && (!key_stored || key_prefix))
          begin
            act_key_load = 1'b1;
            act_keep     = 1'b1;
          end
          else
            act_fail = 1'b1;
        end
        `CLF_M_CLRKEY:
        begin
          if (key_stored)
            act_key_clr = 1'b1;
          else
            act_fail = 1'b1;
        end
        `CLF_M_KEYERASE:
        begin
          if (!key_stored)
          begin
            // without a key the ownership flag is a don't care
            if (card.locked && !wprot[`CLF_WP_PERM])
              act_erase = 1'b1;
            else
              act_fail = 1'b1;
          end
          else if (card.locked && pwd_stored && data_ok && key_exact
                   && !wprot[`CLF_WP_PERM])
            act_erase = 1'b1;
          else
            act_fail = 1'b1;
        end
        default:
        begin
          if (cmd.mode[`CLF_F_OWN] && key_stored)
            act_fail = 1'b1;
          else
          begin
            case ({1'b0, cmd.mode[3:0]})
              `CLF_M_ERASE:
              begin
                if (key_stored || !card.locked || wprot[`CLF_WP_PERM])
                  act_fail = 1'b1;
                else
                  act_erase = 1'b1;
              end
              `CLF_M_UNLOCK:
              begin
                if (card.locked && data_ok && pwd_exact)
                  act_unlock = 1'b1;
                else
                  act_fail = 1'b1;
              end
              `CLF_M_LOCK:
              begin
                if (!card.locked && data_ok && pwd_exact)
                  act_lock = 1'b1;
                else
                  act_fail = 1'b1;
              end
              `CLF_M_SETPWD,
              `CLF_M_SETLOCK:
              begin
                if (data_ok && pwd_new_ok && (!pwd_stored || pwd_prefix))
                begin
                  act_pwd_load = 1'b1;
                  act_lock     = cmd.mode[`CLF_F_LOCK];
                  act_unlock   = !cmd.mode[`CLF_F_LOCK];
                end
                else
                  act_fail = 1'b1;
              end
              `CLF_M_CLRPWD:
              begin
                if (!key_stored && data_ok && pwd_exact)
                begin
                  act_pwd_clr = 1'b1;
                  act_unlock  = 1'b1;
                end
                else
                  act_fail = 1'b1;
              end
              default:
                act_fail = 1'b1;
            endcase
          end
        end
      endcase
    end
  end

  // erase engine: stays busy until software reports the user area done
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          if (act_erase)
            state <= ST_ERASE;
        ST_ERASE:
          if (erase_fin)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // lock and failure flags: one process, so the struct has one driver;
  // erase keeps the card locked until finished; set-key keeps failed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      card.locked <= 1'b0;
      card.failed <= 1'b0;
    end
    else
    begin
      if (erase_fin)
        card.locked <= 1'b0;
      else if (act_unlock)
        card.locked <= 1'b0;
      else if (act_lock)
        card.locked <= 1'b1;
      if (act_fail)
        card.failed <= 1'b1;
      else if (cmd_go && !act_keep)
        card.failed <= 1'b0;
    end
  end

  // ownership unlock and extended set are kept until reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      own_seen  <= 1'b0;
      ext_en    <= 1'b0;
      last_mode <= 5'h00;
    end
    else
    begin
      // any accepted ownership unlock since reset opens the session, so a key
      // stored right after it does not lock the host out
      if (act_own || act_ext)
        own_seen <= 1'b1;
      if (act_ext)
        ext_en <= 1'b1;
      if (cmd_go)
        last_mode <= cmd.mode;
    end
  end

  // response word carries the two flags; one cycle behind the state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      card_status_o <= 32'h0000_0000;
    else
    begin
      card_status_o                 <= 32'h0000_0000;
      card_status_o[`CLF_ST_LOCKED] <= card.locked;
      card_status_o[`CLF_ST_FAILED] <= card.failed;
    end
  end

  // wishbone: one-cycle registered ack, every address answered
  assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr     = wb_req && wb_we_i && wb_sel_i[0];
  assign erase_fin = (state == ST_ERASE) && wb_wr
                     && (wb_adr_i == `CLF_REG_ERASE)
                     && wb_dat_i[`CLF_ERASE_DONE];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  // write protect bits; finishing an erase clears the temporary ones
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wprot <= `CLF_WPROT_RST;
    else
    begin
      if (wb_wr && wb_adr_i == `CLF_REG_WPROT)
        wprot <= wb_dat_i[2:0];
      if (erase_fin)
      begin
        wprot[`CLF_WP_TEMP]  <= 1'b0;
        wprot[`CLF_WP_GROUP] <= 1'b0;
      end
    end
  end

  // read data: unmapped offsets read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        `CLF_REG_STATUS:
          wb_dat_o <= {19'h0, last_mode, 1'b0, state == ST_ERASE,
                       ext_en, own_seen, pwd_stored, key_stored,
                       card.failed, card.locked};
        `CLF_REG_WPROT:
          wb_dat_o <= {29'h0, wprot};
        `CLF_REG_ERASE:
          wb_dat_o <= {31'h0, state == ST_ERASE};
        `CLF_REG_LENS:
          wb_dat_o <= {16'h0, key_len, password_length};
        default:
          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== rtl/clf_params.svh
// clf_params.svh: offsets, field positions, codes and sizes of the card
// lock block. assumes it is included by bare name from design files.
`ifndef CLF_PARAMS_SVH
`define CLF_PARAMS_SVH

// wishbone register byte offsets
`define CLF_REG_STATUS     8'h00
`define CLF_REG_WPROT      8'h04
`define CLF_REG_ERASE      8'h08
`define CLF_REG_LENS       8'h0c

// write protect register fields
`define CLF_WP_PERM        0
`define CLF_WP_TEMP        1
`define CLF_WP_GROUP       2
`define CLF_WPROT_RST      3'h0

// erase register: write one reports user area erased
`define CLF_ERASE_DONE     0

// mode byte flag positions
`define CLF_F_OWN          4
`define CLF_F_ERASE        3
`define CLF_F_LOCK         2
`define CLF_F_CLR          1
`define CLF_F_SET          0

// mode codes
`define CLF_M_UNLOCK       5'h00
`define CLF_M_SETPWD       5'h01
`define CLF_M_CLRPWD       5'h02
`define CLF_M_LOCK         5'h04
`define CLF_M_SETLOCK      5'h05
`define CLF_M_ERASE        5'h08
`define CLF_M_SETKEY       5'h11
`define CLF_M_CLRKEY       5'h12
`define CLF_M_KEYERASE     5'h18
`define CLF_M_OWNUNLOCK    5'h1f

// card status word bit positions
`define CLF_ST_LOCKED      25
`define CLF_ST_FAILED      24

// secret sizes in bytes
`define CLF_SECRET_MAX     16

`endif

// ===== rtl/clf_pkg.sv
// clf_pkg: types shared by the card lock block.
// assumes clf_params.svh is on the include path.
`include "clf_params.svh"

package clf_pkg;

  // control state of the command engine
  typedef enum logic [0:0]
  {
    ST_IDLE,
    ST_ERASE
  } clf_state_t;

  // decoded header of one data block
  typedef struct packed
  {
    logic [4:0] mode;
    logic [7:0] size;
  } clf_cmd_t;

  // flags reported in the response status word
  typedef struct packed
  {
    logic locked;
    logic failed;
  } clf_card_t;

endpackage

// ===== rtl/clf_secret.sv
// clf_secret: store for one secret (password or override key) and its
// length, with comparison against a received data block.
// assumes block byte i sits at blk_i[i*8 +: 8], after mode and size.
`timescale 1ns/1ps

module clf_secret
#(
  parameter int SMAX = 16,
  parameter int BMAX = 32
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // received block
  input  wire logic [BMAX*8-1:0] blk_i,
  input  wire logic [7:0]        size_i,
  // actions
  input  wire logic              load_i,
  input  wire logic              clear_i,
  // state and comparison
  output logic      [7:0]        len_o,
  output logic                   stored_o,
  output logic                   exact_o,
  output logic                   prefix_o,
  output logic                   new_ok_o
);

  logic [7:0] mem [SMAX];
  logic       eq;
  logic [7:0] off;
  logic [7:0] new_len;

  assign stored_o = (len_o != 8'h00);
  // a stored secret means old then new; otherwise only the new one
  assign off      = stored_o ? len_o : 8'h00;
  assign new_len  = size_i - off;
  assign new_ok_o = (size_i > off) && (new_len <= 8'(SMAX));
  assign exact_o  = stored_o && eq && (size_i == len_o);
  assign prefix_o = stored_o && eq && (size_i > len_o);

  // compare stored bytes with the leading bytes of the block
  always_comb
  begin
    eq = 1'b1;
    for (int i = 0; i < SMAX; i++)
    begin
      if ((8'(i) < len_o) && (blk_i[i*8 +: 8] != mem[i]))
        eq = 1'b0;
    end
  end

  // load the new secret from behind the old one, or clear both
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      len_o <= 8'h00;
      for (int i = 0; i < SMAX; i++)
        mem[i] <= 8'h00;
    end
    else if (load_i)
    begin
      len_o <= new_len;
      for (int i = 0; i < SMAX; i++)
      begin
        if (i + int'(off) < BMAX)
          mem[i] <= blk_i[(i + int'(off))*8 +: 8];
        else
          mem[i] <= 8'h00;
      end
    end
  end

endmodule

// ===== rtl/clf_sync.sv
// clf_sync: two flip-flop synchroniser for a bundle of pin levels.
// assumes each bit changes no faster than the sampling clock can see.
`timescale 1ns/1ps

module clf_sync
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // levels
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule
